// ===== include/osr_pkg.sv
`default_nettype none
package osr_pkg;
  // ****************************************************************
  // Register map (word indices, byte address = 4 * index)
  // ****************************************************************
  localparam logic [17:0] ADDR_HI_ZERO  = 18'h00000;
  localparam logic [11:0] IDX_GLOBAL    = 12'h000;
  localparam logic [11:0] IDX_STATUS    = 12'h00F;
  localparam logic [3:0]  PAGE_MUX01    = 4'h1;
  localparam logic [3:0]  PAGE_MUX23    = 4'h4;
  localparam logic [7:0]  OFF_SLOT01    = 8'h01;
  localparam logic [7:0]  OFF_SLOT67    = 8'h04;
  localparam logic [7:0]  OFF_SER_FIRST = 8'h06;
  localparam logic [7:0]  OFF_SER_LAST  = 8'h08;
  localparam int          MUXES         = 2;
  localparam int          CHANS         = 4;
  localparam int          SLOT_REGS     = 4;
  localparam int          SER_WORDS     = 3;
  // ****************************************************************
  // Field positions and masks
  // ****************************************************************
  localparam int BYTE_LO_LSB     = 0;
  localparam int BYTE_HI_LSB     = 4;
  localparam int EN_FIRST_BIT    = 8;
  localparam int EN_SECOND_BIT   = 9;
  localparam int FSYNC_BIT       = 10;
  localparam int UPPER_FIELD_LSB = 16;
  localparam int INVERT_BIT      = 27;
  localparam int TSRC_LSB        = 28;
  localparam int SERIAL_MODE_BIT = 31;
  localparam int SCLK_EN_BIT     = 29;
  localparam int SSYNC_POL_BIT   = 28;
  localparam int SSYNC_POS_LSB   = 24;
  localparam int SD1_MASK_LSB    = 16;
  localparam int SD2_MASK_LSB    = 12;
  localparam logic [31:0] RST_WORD      = 32'h00000000;
  localparam logic [31:0] SLOT_MASK     = 32'h07FF07FF;
  localparam logic [31:0] SLOT01_MASK   = 32'h3FFF07FF;
  localparam logic [31:0] GLOBAL_MASK   = 32'h80000000;
  localparam logic [31:0] SER_CTRL_MASK = 32'h330FF000;
  localparam logic [31:0] FULL_MASK     = 32'hFFFFFFFF;
  // ****************************************************************
  // Timing and sequencing
  // ****************************************************************
  localparam logic [1:0] SCLK_HALF_M1  = 2'h1;
  localparam logic [4:0] SER_DATA_BITS = 5'h10;
  localparam logic [4:0] SER_LAST_POS  = 5'h10;
  localparam logic [4:0] SER_FIRST_EARLY = 5'h01;
  localparam logic [4:0] SER_POS_ZERO  = 5'h00;
  localparam logic [2:0] SLOT_LAST     = 3'h7;
  localparam logic [1:0] FIFO_DEPTH    = 2'h2;
  typedef enum logic {SEQ_IDLE, SEQ_RUN} osr_seq_t;
endpackage : osr_pkg
`default_nettype wire

// ===== logic/osr_router.sv
// Operation
// - Slots four/five word: slot five field 26:16, slot four field 10:0, rest zero.
// - Slots six/seven word: slot seven field 26:16, slot six field 10:0.
// - Selector codes 0-7 pick I, Q, then gain bytes of the lower channel.
// - Selector top bit picks the upper channel; pairs are channels 0/1 and 2/3.
// - Global bit 31 turns the fourth parallel bus into serial outputs.
// - Serial channel owns four bus bits: clock, sync, data one, data two.
// - One shared generator makes all four serial bit clocks.
// - Each serial bit clock output has its own enable.
// - Serial words go out most significant bit first.
// - Serial control: three words at offsets 06h-08h in a one-hot channel page.
// - Slot field bits 3:0 pick low byte, bits 7:4 pick high byte.
// - Slot bit 8 drives the mux's first bus (A or B), bit 9 its second bus (C or D), bit 10 frame sync.
// - Slot counter restarts on a new sample from the timing-source channel.
// - Invert bit drives the ones complement of the routed word.
`default_nettype none
module osr_router
  import osr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        smp_valid,
  output logic             smp_ready,
  input  wire logic [1:0]  smp_chan,
  input  wire logic [23:0] smp_i,
  input  wire logic [23:0] smp_q,
  input  wire logic [15:0] smp_gain,
  input  wire logic        sink_ready,
  output logic [15:0]      bus_a_data,
  output logic             bus_a_oe,
  output logic             parallel_frame_sync_a,
  output logic [15:0]      bus_b_data,
  output logic             bus_b_oe,
  output logic             parallel_frame_sync_b,
  output logic [15:0]      bus_c_data,
  output logic             bus_c_oe,
  output logic             parallel_frame_sync_c,
  output logic [15:0]      bus_d_data,
  output logic             bus_d_oe,
  output logic             parallel_frame_sync_d
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Slot register decode: {hit, mux, register}
  function automatic logic [3:0] osr_slot_dec(input logic [11:0] idx);
    logic [7:0] off;
    off = idx[7:0];
    osr_slot_dec = 4'h0;
    if (off >= OFF_SLOT01 && off <= OFF_SLOT67) begin
      if (idx[11:8] == PAGE_MUX01) begin
        osr_slot_dec = {2'b10, 2'(off - OFF_SLOT01)};
      end else if (idx[11:8] == PAGE_MUX23) begin
        osr_slot_dec = {2'b11, 2'(off - OFF_SLOT01)};
      end
    end
  endfunction : osr_slot_dec

  // Serial control decode from one-hot page: {hit, channel, word}
  function automatic logic [4:0] osr_ser_dec(input logic [11:0] idx);
    logic [7:0] off;
    logic [1:0] ch;
    logic       ok;
    off = idx[7:0];
    ok  = 1'b1;
    ch  = 2'h0;
    unique case (idx[11:8])
      4'h1:    ch = 2'h0;
      4'h2:    ch = 2'h1;
      4'h4:    ch = 2'h2;
      4'h8:    ch = 2'h3;
      default: ok = 1'b0;
    endcase
    if (off < OFF_SER_FIRST || off > OFF_SER_LAST) begin
      ok = 1'b0;
    end
    osr_ser_dec = {ok, ch, 2'(off - OFF_SER_FIRST)};
  endfunction : osr_ser_dec

  // Byte pick from a channel pair; bundle is {I, Q, gain}
  function automatic logic [7:0] osr_pick(input logic [3:0]  code,
                                         input logic [63:0] lo,
                                         input logic [63:0] hi);
    logic [63:0] b;
    b = code[3] ? hi : lo;
    unique case (code[2:0])
      3'h0: osr_pick = b[63:56];
      3'h1: osr_pick = b[55:48];
      3'h2: osr_pick = b[47:40];
      3'h3: osr_pick = b[39:32];
      3'h4: osr_pick = b[31:24];
      3'h5: osr_pick = b[23:16];
      3'h6: osr_pick = b[15:8];
      3'h7: osr_pick = b[7:0];
    endcase
  endfunction : osr_pick

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [31:0] global_q;
  logic [31:0] slot_q [MUXES][SLOT_REGS];
  logic [31:0] ser_q  [CHANS][SER_WORDS];
  logic [63:0] chan_smp_q [CHANS];
  logic [65:0] fifo_q [2];
  logic        wr_ptr_q;
  logic        rd_ptr_q;
  logic [1:0]  fifo_cnt_q;
  logic        smp_ready_q;
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  osr_seq_t    seq_q  [MUXES];
  logic [2:0]  slot_cnt_q [MUXES];
  logic [15:0] bus_data_q [4];
  logic        bus_oe_q   [4];
  logic        fsync_q    [4];
  logic [1:0]  div_q;
  logic        sclk_q;
  logic        ser_pend_q [CHANS];
  logic        ser_act_q  [CHANS];
  logic [4:0]  ser_pos_q  [CHANS];
  logic [15:0] sh1_q      [CHANS];
  logic [15:0] sh2_q      [CHANS];
  logic [31:0] rd_val;
  logic        rd_hit;
  logic [11:0] idx;
  logic [3:0]  sdec;
  logic [4:0]  cdec;
  logic        wr_en;
  logic        push;
  logic        pop;
  logic [65:0] head;
  logic        tick;
  logic        serial_mode;
  logic [15:0] ser_word;

  assign idx         = paddr[13:2];
  assign sdec        = osr_slot_dec(idx);
  assign cdec        = osr_ser_dec(idx);
  assign wr_en       = psel & penable & pready_q & pwrite & rd_hit;
  assign serial_mode = global_q[SERIAL_MODE_BIT];
  assign push        = smp_valid & smp_ready_q;
  assign pop         = (fifo_cnt_q != 2'h0) & sink_ready;
  assign head        = fifo_q[rd_ptr_q];
  assign tick        = sclk_q & (div_q == SCLK_HALF_M1);

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // Register read decode
  always_comb begin
    rd_val = RST_WORD;
    rd_hit = 1'b0;
    if (paddr[31:14] == ADDR_HI_ZERO && paddr[1:0] == 2'b00) begin
      if (idx == IDX_GLOBAL) begin
        rd_hit = 1'b1;
        rd_val = global_q;
      end else if (idx == IDX_STATUS) begin
        rd_hit = 1'b1;
        rd_val = {16'h0000, serial_mode, seq_q[1] == SEQ_RUN, seq_q[0] == SEQ_RUN,
                  slot_cnt_q[1], slot_cnt_q[0], ser_act_q[3], ser_act_q[2],
                  ser_act_q[1], ser_act_q[0], 1'b0, fifo_cnt_q};
      end else if (sdec[3]) begin
        rd_hit = 1'b1;
        rd_val = slot_q[sdec[2]][sdec[1:0]];
      end else if (cdec[4]) begin
        rd_hit = 1'b1;
        rd_val = ser_q[cdec[3:2]][cdec[1:0]];
      end
    end
  end

  // One wait state, registered answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= RST_WORD;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      if (psel && penable && !pready_q) begin
        pready_q  <= 1'b1;
        prdata_q  <= pwrite ? RST_WORD : rd_val;
        pslverr_q <= !rd_hit;
      end else begin
        pready_q  <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end

  // Register writes, reserved bits forced to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_q <= RST_WORD;
      for (int m = 0; m < MUXES; m++) begin
        for (int r = 0; r < SLOT_REGS; r++) begin
          slot_q[m][r] <= RST_WORD;
        end
      end
      for (int c = 0; c < CHANS; c++) begin
        for (int w = 0; w < SER_WORDS; w++) begin
          ser_q[c][w] <= RST_WORD;
        end
      end
    end else if (ce && wr_en) begin
      if (idx == IDX_GLOBAL) begin
        global_q <= pwdata & GLOBAL_MASK;
      end else if (sdec[3]) begin
        slot_q[sdec[2]][sdec[1:0]] <=
          pwdata & ((sdec[1:0] == 2'h0) ? SLOT01_MASK : SLOT_MASK);
      end else if (cdec[4]) begin
        ser_q[cdec[3:2]][cdec[1:0]] <=
          pwdata & ((cdec[1:0] == 2'h0) ? SER_CTRL_MASK : FULL_MASK);
      end
    end
  end

  // ****************************************************************
  // Sample buffer
  // ****************************************************************
  // Two-entry FIFO; sink_ready low stalls it and back-pressures the source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_q[0]   <= 66'h0;
      fifo_q[1]   <= 66'h0;
      wr_ptr_q    <= 1'b0;
      rd_ptr_q    <= 1'b0;
      fifo_cnt_q  <= 2'h0;
      smp_ready_q <= 1'b0;
    end else if (ce) begin
      if (push) begin
        fifo_q[wr_ptr_q] <= {smp_chan, smp_i, smp_q, smp_gain};
        wr_ptr_q         <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      fifo_cnt_q  <= 2'(fifo_cnt_q + {1'b0, push} - {1'b0, pop});
      smp_ready_q <= 2'(fifo_cnt_q + {1'b0, push} - {1'b0, pop}) < FIFO_DEPTH;
    end
  end

  // Latch the newest sample of each channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < CHANS; c++) begin
        chan_smp_q[c] <= 64'h0;
      end
    end else if (ce && pop) begin
      chan_smp_q[head[65:64]] <= head[63:0];
    end
  end

  // ****************************************************************
  // Slot sequencers
  // ****************************************************************
  // Restart on timing-source sample, then walk slots zero to seven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int m = 0; m < MUXES; m++) begin
        seq_q[m]      <= SEQ_IDLE;
        slot_cnt_q[m] <= 3'h0;
      end
    end else if (ce) begin
      for (int m = 0; m < MUXES; m++) begin
        if (pop && head[65:64] == slot_q[m][0][TSRC_LSB +: 2]) begin
          seq_q[m]      <= SEQ_RUN;
          slot_cnt_q[m] <= 3'h0;
        end else begin
          unique case (seq_q[m])
            SEQ_IDLE: seq_q[m] <= SEQ_IDLE;
            SEQ_RUN: begin
              slot_cnt_q[m] <= 3'(slot_cnt_q[m] + 3'h1);
              if (slot_cnt_q[m] == SLOT_LAST) begin
                seq_q[m] <= SEQ_IDLE;
              end
            end
          endcase
        end
      end
    end
  end

  // Parallel bus drive; mux 0 feeds buses A/C, mux 1 feeds B/D
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int b = 0; b < 4; b++) begin
        bus_data_q[b] <= 16'h0000;
        bus_oe_q[b]   <= 1'b0;
        fsync_q[b]    <= 1'b0;
      end
    end else if (ce) begin
      for (int m = 0; m < MUXES; m++) begin
        logic [31:0] word;
        logic [10:0] fld;
        logic [15:0] val;
        logic        run;
        word = slot_q[m][slot_cnt_q[m][2:1]];
        fld  = slot_cnt_q[m][0] ? word[UPPER_FIELD_LSB +: 11] : word[10:0];
        val  = {osr_pick(fld[BYTE_HI_LSB +: 4], chan_smp_q[2*m], chan_smp_q[2*m+1]),
                osr_pick(fld[BYTE_LO_LSB +: 4], chan_smp_q[2*m], chan_smp_q[2*m+1])};
        if (slot_q[m][0][INVERT_BIT]) begin
          val = ~val;
        end
        run = (seq_q[m] == SEQ_RUN);
        bus_data_q[m]   <= val;
        bus_oe_q[m]     <= run & fld[EN_FIRST_BIT];
        fsync_q[m]      <= run & fld[EN_FIRST_BIT] & fld[FSYNC_BIT];
        if (m == 1 && serial_mode) begin
          bus_data_q[3] <= ser_word;
          bus_oe_q[3]   <= 1'b1;
          fsync_q[3]    <= 1'b0;
        end else begin
          bus_data_q[m+2] <= val;
          bus_oe_q[m+2]   <= run & fld[EN_SECOND_BIT];
          fsync_q[m+2]    <= run & fld[EN_SECOND_BIT] & fld[FSYNC_BIT];
        end
      end
    end
  end

  // ****************************************************************
  // Serial ports
  // ****************************************************************
  // Shared bit clock generator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= 2'h0;
      sclk_q <= 1'b0;
    end else if (ce) begin
      if (div_q == SCLK_HALF_M1) begin
        div_q  <= 2'h0;
        sclk_q <= ~sclk_q;
      end else begin
        div_q <= 2'(div_q + 2'h1);
      end
    end
  end

  // Per-channel word shifters, advanced on the falling bit clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < CHANS; c++) begin
        ser_pend_q[c] <= 1'b0;
        ser_act_q[c]  <= 1'b0;
        ser_pos_q[c]  <= 5'h00;
        sh1_q[c]      <= 16'h0000;
        sh2_q[c]      <= 16'h0000;
      end
    end else if (ce) begin
      for (int c = 0; c < CHANS; c++) begin
        logic [4:0] first;
        first = (ser_q[c][0][SSYNC_POS_LSB +: 2] == 2'b00) ? SER_FIRST_EARLY : SER_POS_ZERO;
        if (pop && serial_mode && head[65:64] == 2'(c)) begin
          ser_pend_q[c] <= 1'b1;
          sh1_q[c]      <= head[63:48];
          sh2_q[c]      <= head[39:24];
        end else if (tick) begin
          if (ser_pend_q[c]) begin
            ser_pend_q[c] <= 1'b0;
            ser_act_q[c]  <= 1'b1;
            ser_pos_q[c]  <= SER_POS_ZERO;
          end else if (ser_act_q[c]) begin
            ser_pos_q[c] <= 5'(ser_pos_q[c] + 5'h01);
            if (ser_pos_q[c] >= first) begin
              sh1_q[c] <= {sh1_q[c][14:0], 1'b0};
              sh2_q[c] <= {sh2_q[c][14:0], 1'b0};
            end
            if (ser_pos_q[c] == SER_LAST_POS) begin
              ser_act_q[c] <= 1'b0;
            end
          end
        end
      end
    end
  end

  // Pin word: gated data and syncs ORed across channels, then polarity
  always_comb begin
    logic [3:0] sd1;
    logic [3:0] sd2;
    logic [3:0] syn;
    logic [3:0] o1;
    logic [3:0] o2;
    logic [3:0] os;
    logic [4:0] first;
    sd1   = 4'h0;
    sd2   = 4'h0;
    syn   = 4'h0;
    o1    = 4'h0;
    o2    = 4'h0;
    os    = 4'h0;
    first = SER_POS_ZERO;
    ser_word = 16'h0000;
    for (int c = 0; c < CHANS; c++) begin
      first = (ser_q[c][0][SSYNC_POS_LSB +: 2] == 2'b00) ? SER_FIRST_EARLY : SER_POS_ZERO;
      if (ser_act_q[c] && ser_pos_q[c] >= first &&
          ser_pos_q[c] < 5'(first + SER_DATA_BITS)) begin
        sd1[c] = sh1_q[c][15];
        sd2[c] = sh2_q[c][15];
      end
      syn[c] = ser_act_q[c] && (ser_pos_q[c] ==
               ((ser_q[c][0][SSYNC_POS_LSB +: 2] == 2'b01) ? SER_LAST_POS : SER_POS_ZERO));
    end
    for (int k = 0; k < CHANS; k++) begin
      for (int c = 0; c < CHANS; c++) begin
        o1[k] = o1[k] | (sd1[c] & ser_q[c][0][SD1_MASK_LSB + k]);
        o2[k] = o2[k] | (sd2[c] & ser_q[c][0][SD2_MASK_LSB + k]);
        os[k] = os[k] | (syn[c] & ser_q[c][0][SD1_MASK_LSB + k]);
      end
      ser_word[4*k]   = sclk_q & ser_q[k][0][SCLK_EN_BIT];
      ser_word[4*k+1] = os[k] ^ ser_q[k][0][SSYNC_POL_BIT];
      ser_word[4*k+2] = o1[k];
      ser_word[4*k+3] = o2[k];
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign pready                = pready_q;
  assign prdata                = prdata_q;
  assign pslverr               = pslverr_q;
  assign smp_ready             = smp_ready_q;
  assign bus_a_data            = bus_data_q[0];
  assign bus_a_oe              = bus_oe_q[0];
  assign parallel_frame_sync_a = fsync_q[0];
  assign bus_b_data            = bus_data_q[1];
  assign bus_b_oe              = bus_oe_q[1];
  assign parallel_frame_sync_b = fsync_q[1];
  assign bus_c_data            = bus_data_q[2];
  assign bus_c_oe              = bus_oe_q[2];
  assign parallel_frame_sync_c = fsync_q[2];
  assign bus_d_data            = bus_data_q[3];
  assign bus_d_oe              = bus_oe_q[3];
  assign parallel_frame_sync_d = fsync_q[3];

endmodule : osr_router
`default_nettype wire

// ===== dv/osr_chk.sv
`default_nettype none
// **********************
// Port checker
// **********************
module osr_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        smp_ready,
  input wire logic        sink_ready,
  input wire logic        bus_a_oe,
  input wire logic        parallel_frame_sync_a,
  input wire logic        bus_c_oe,
  input wire logic        parallel_frame_sync_c,
  input wire logic [15:0] bus_d_data,
  input wire logic        bus_d_oe,
  input wire logic        parallel_frame_sync_d
);
  logic       mode_q;
  logic [3:0] sclk_en_q;
  logic [1:0] age_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow of serial mode and bit clock enables, cycles since last write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q    <= 1'b0;
      sclk_en_q <= 4'h0;
      age_q     <= 2'h0;
    end else if (psel && penable && pready && pwrite && !pslverr) begin
      age_q <= 2'h0;
      if (paddr == 32'h00000000) mode_q <= pwdata[31];
      for (int c = 0; c < 4; c++) begin
        if (paddr[13:10] == 4'(1 << c) && paddr[9:2] == 8'h06) sclk_en_q[c] <= pwdata[29];
      end
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
  property p_ready_cause; pready |-> $past(psel && penable); endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
  property p_fsync_a; parallel_frame_sync_a |-> bus_a_oe; endproperty
  a_fsync_a: assert property (p_fsync_a) else $error("sync a undriven");
  property p_fsync_c; parallel_frame_sync_c |-> bus_c_oe; endproperty
  a_fsync_c: assert property (p_fsync_c) else $error("sync c undriven");
  property p_serial_bus; age_q == 2'h3 && mode_q |-> bus_d_oe && !parallel_frame_sync_d; endproperty
  a_serial_bus: assert property (p_serial_bus) else $error("bus d not serial");
  property p_sclk_sync;
    age_q == 2'h3 && mode_q && sclk_en_q[0] && sclk_en_q[1] |-> bus_d_data[0] == bus_d_data[4];
  endproperty
  a_sclk_sync: assert property (p_sclk_sync) else $error("bit clocks apart");
  property p_sclk_off; age_q == 2'h3 && mode_q && !sclk_en_q[2] |-> !bus_d_data[8]; endproperty
  a_sclk_off: assert property (p_sclk_off) else $error("bit clock not held off");
  property p_full_hold; !smp_ready && !sink_ready |=> !smp_ready; endproperty
  a_full_hold: assert property (p_full_hold) else $error("full buffer took a sample");
endmodule : osr_chk
bind osr_router osr_chk osr_chk_inst (.*);
`default_nettype wire

// ===== dv/osr_sink.sv
`default_nettype none
// **********************
// Downstream receiver
// **********************
module osr_sink (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        stall,
  output logic             sink_ready,
  input  wire logic [15:0] bus_a_data,
  input  wire logic        bus_a_oe,
  input  wire logic        parallel_frame_sync_a,
  input  wire logic [15:0] bus_d_data,
  input  wire logic        bus_d_oe
);
  logic [16:0] par_q [$];
  logic [15:0] line1_q;
  logic [15:0] line2_q;
  logic [4:0]  left_q;
  logic        sclk_q;
  // Back-pressure on request of the bench
  assign sink_ready = !stall;
  // Words taken while bus A is driven, with their frame sync
  always @(posedge pclk) begin
    if (bus_a_oe) par_q.push_back({parallel_frame_sync_a, bus_a_data});
  end
  // Serial port 0: sync arms sixteen samples on rising bit clock, only while bus D is driven
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 1'b0;
      left_q <= 5'h00;
    end else begin
      sclk_q <= bus_d_data[0] & bus_d_oe;
      if (bus_d_oe && bus_d_data[0] && !sclk_q) begin
        if (bus_d_data[1]) begin
          left_q <= 5'h10;
        end else if (left_q != 5'h00) begin
          line1_q <= {line1_q[14:0], bus_d_data[2]};
          line2_q <= {line2_q[14:0], bus_d_data[3]};
          left_q  <= left_q - 5'h01;
        end
      end
    end
  end
endmodule : osr_sink
`default_nettype wire

// ===== dv/tb.sv
`default_nettype none
module tb
  import osr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] V0 = 64'h99AABBCCDDEEF0E1;
  localparam logic [63:0] V1 = 64'h1122334455667788;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
  logic        smp_valid, smp_ready, sink_ready, stall;
  logic        bus_a_oe, bus_b_oe, bus_c_oe, bus_d_oe;
  logic        parallel_frame_sync_a, parallel_frame_sync_b;
  logic        parallel_frame_sync_c, parallel_frame_sync_d;
  logic [1:0]  smp_chan;
  logic [15:0] smp_gain, bus_a_data, bus_b_data, bus_c_data, bus_d_data;
  logic [16:0] ex;
  logic [23:0] smp_i, smp_q;
  logic [31:0] paddr, pwdata, prdata, rd;
  int          err_total, total_checks;
  osr_router osr_router_inst (.*);
  osr_sink   osr_sink_inst (.*);
  // Free-running clock
  always #5 pclk = ~pclk;
  // **********************
  // Access tasks
  // **********************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic smp(input logic [1:0] c, input logic [63:0] v);
    @(posedge pclk);
    smp_valid <= 1'b1;
    smp_chan  <= c;
    {smp_i, smp_q, smp_gain} <= v;
    do @(posedge pclk); while (smp_ready !== 1'b1);
    smp_valid <= 1'b0;
  endtask : smp
  function automatic logic [7:0] byt(input logic [3:0] c);
    logic [63:0] v;
    v = c[3] ? V1 : V0;
    return v[63 - 8 * c[2:0] -: 8];
  endfunction : byt
  function automatic logic [10:0] fld(input int k);
    return {k == 0, k == 0, k != 5, 4'(2 * k), 4'(2 * k + 1)};
  endfunction : fld
  task automatic cfg(input logic inv);
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, 32'h404 + 4 * r, {4'h0, inv && r == 0, fld(2 * r + 1), 5'h00, fld(2 * r)});
    end
  endtask : cfg
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // **********************
  // Tests
  // **********************
  initial begin
    {pclk, presetn, ce, psel, penable, pwrite, smp_valid, stall} = 8'h20;
    {paddr, pwdata, smp_chan, smp_i, smp_q, smp_gain} = '0;
    err_total = 0;
    total_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Reset value and reserved bits of the upper slot words, then a hole
    for (int r = 2; r < 4; r++) begin
      apb(1'b0, 32'h404 + 4 * r, 32'h0);
      chk("slot word reset", RST_WORD, rd);
      apb(1'b1, 32'h404 + 4 * r, FULL_MASK);
      apb(1'b0, 32'h404 + 4 * r, 32'h0);
      chk("slot word mask", SLOT_MASK, rd);
    end
    apb(1'b0, 32'h3FC, 32'h0);
    chk("unmapped error", 32'h1, er);
    // Sink stalls while channel 1 fills the buffer, then drains it
    cfg(1'b0);
    stall <= 1'b1;
    smp(2'h1, ~V1);
    smp(2'h1, V1);
    @(posedge pclk);
    chk("buffer full", 32'h0, smp_ready);
    apb(1'b0, 32'h3C, 32'h0);
    chk("fill two", 32'h2, rd[1:0]);
    stall <= 1'b0;
    apb(1'b0, 32'h3C, 32'h0);
    chk("fill zero", 32'h0, rd[1:0]);
    chk("no restart", 32'h0, osr_sink_inst.par_q.size());
    // Slot sequence on bus A from channel 0, plain then inverted
    for (int inv = 0; inv < 2; inv++) begin
      cfg(inv[0]);
      osr_sink_inst.par_q.delete();
      smp(2'h0, V0);
      repeat (20) @(posedge pclk);
      chk("slot count", 32'h7, osr_sink_inst.par_q.size());
      for (int k = 0; k < 8; k++) begin
        ex = {k == 0, {byt(4'(2 * k)), byt(4'(2 * k + 1))} ^ {16{inv[0]}}};
        if (k != 5) chk("bus a word", ex, osr_sink_inst.par_q[k - (k > 5)]);
      end
    end
    // Second pair: channel 2 restarts mux 1, bus B slot 0 mixes channels 2 and 3
    apb(1'b1, 32'h1004, 32'h20000508);
    smp(2'h3, V1);
    smp(2'h2, V0);
    repeat (3) @(posedge pclk);
    chk("bus b word", {byt(4'h0), byt(4'h8)}, bus_b_data);
    chk("bus b sync", 32'h1, parallel_frame_sync_b);
    chk("bus b enable", 32'h1, bus_b_oe);
    // Serial mode on bus D, bit clocks on for channels 0 and 1
    apb(1'b1, 32'h000, 32'h80000000);
    apb(1'b1, 32'h418, 32'h20011000);
    apb(1'b1, 32'h818, 32'h20000000);
    apb(1'b0, 32'h000, 32'h0);
    chk("serial mode", GLOBAL_MASK, rd);
    smp(2'h0, V0);
    repeat (100) @(posedge pclk);
    chk("serial line one", V0[63:48], osr_sink_inst.line1_q);
    chk("serial line two", V0[39:24], osr_sink_inst.line2_q);
    chk("serial bus driven", 32'h1, bus_d_oe);
    report_and_stop();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
